/* rtl/tcw_pkg.sv */
// Purpose: shared constants and types for the 8-bit timer compare unit
// Assumes: one clock, timer clock enable supplied from outside
// Notes:   register offsets are word indices on the plain register port
package tcw_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_COUNT  = 4'h1;
    localparam logic [3:0] ADDR_CMP    = 4'h2;
    localparam logic [3:0] ADDR_FLAGS  = 4'h3;
    localparam logic [3:0] ADDR_PORT   = 4'h4;

    // ctrl fields: [7] force strobe, [5:4] output mode, [1:0] waveform mode
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_COM_LSB   = 4;
    localparam int CTRL_WGM_LSB   = 0;
    // flags: [0] overflow, [1] compare
    localparam int FLAG_OVF_BIT   = 0;
    localparam int FLAG_CMP_BIT   = 1;
    // port: [0] port output value, [1] pin direction
    localparam int PORT_OUT_BIT   = 0;
    localparam int PORT_DIR_BIT   = 1;

    // ************************************************
    // reset values and counter extremes
    // ************************************************
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [1:0] COM_OFF      = 2'h0;
    localparam logic [1:0] COM_TOGGLE   = 2'h1;
    localparam logic [1:0] COM_CLEAR    = 2'h2;
    localparam logic [1:0] COM_SET      = 2'h3;

    typedef enum logic [1:0] {
        WGM_NORMAL = 2'h0,
        WGM_PHASE  = 2'h1,
        WGM_CLEAR  = 2'h2,
        WGM_FAST   = 2'h3
    } tcw_wgm_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcw_bus_s;

endpackage : tcw_pkg

/* rtl/tcw_timer.sv */
// Purpose: 8-bit timer counter with compare output and waveform modes
// Assumes: tick is the one-cycle timer clock enable from a prescaler
// Notes:   phase correct mode only holds the counter and output still
//
// Contract
// RL1: nonzero output mode routes waveform output to pin instead of port value
// RL2: software sets pin direction; block never changes direction itself
// RL3: pin override depends only on output mode, not waveform mode
// RL4: reset clears waveform output register to zero
// RL5: output mode zero leaves waveform output unchanged on matches
// RL6: new output mode acts from the first match after the write
// RL7: force strobe in non-PWM modes applies the output action at once
// RL8: counting depends only on waveform mode; output mode only shapes output
// RL9: normal mode always increments and wraps 0xFF to 0x00
// RL10: normal mode sets overflow flag as count becomes zero; only sets
// RL11: normal mode accepts a count write at any time
// RL12: clear-on-match mode counts up to compare value then clears
// RL13: compare below count in clear-on-match runs on to 0xFF and wraps
// RL14: clear-on-match compare value takes effect immediately on write
// RL15: clear-on-match with output mode 1 toggles output each match
// RL16: clear-on-match raises compare flag each time count reaches top
// RL17: clear-on-match sets overflow flag on roll from max to zero
// RL18: fast PWM counts up to max then clears next tick
// RL19: fast PWM mode 2 clears at match, sets at bottom; mode 3 inverse
// RL20: fast PWM sets overflow flag as the counter rolls from max to zero
// RL21: fast PWM compare zero gives spike; compare max gives steady level
// RL22: compare buffered in PWM modes, updated at top; direct otherwise
// RL23: match sets compare flag next tick; writing one clears it
// RL24: force strobe sets no flag and leaves the counter alone
// RL25: count write blocks compare matches in the next timer tick
// RL26: counting, matching and output updates other than force strobe only on timer clock enable
`timescale 1ns/100ps
`default_nettype none

module tcw_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic       irq_ack_ovf,
    input  wire logic       irq_ack_cmp,
    output logic      [7:0] rdata,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            ovf_flag,
    output logic            cmp_flag
);

    // ************************************************
    // register port decode
    // ************************************************
    tcw_pkg::tcw_bus_s bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire wr_ctrl  = bus.wr && (bus.addr == tcw_pkg::ADDR_CTRL);
    wire wr_count = bus.wr && (bus.addr == tcw_pkg::ADDR_COUNT);
    wire wr_cmp   = bus.wr && (bus.addr == tcw_pkg::ADDR_CMP);
    wire wr_flags = bus.wr && (bus.addr == tcw_pkg::ADDR_FLAGS);
    wire wr_port  = bus.wr && (bus.addr == tcw_pkg::ADDR_PORT);

    logic [1:0] com_q;
    logic [1:0] wgm_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] cmp_buf_q;
    logic [7:0] cmp_act_q;
    logic       wave_q;
    logic       wave_d;
    logic       ovf_q;
    logic       cmp_q;
    logic       block_q;
    logic       port_out_q;
    logic       port_dir_q;
    logic       pin_out_q;
    logic       pin_oe_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_q_d;

    tcw_pkg::tcw_wgm_e wgm;
    assign wgm = tcw_pkg::tcw_wgm_e'(wgm_q);

    // ************************************************
    // mode decode
    // ************************************************
    wire is_pwm   = wgm_q[0];
    wire is_fast  = (wgm == tcw_pkg::WGM_FAST);
    wire is_clear = (wgm == tcw_pkg::WGM_CLEAR);
    wire is_phase = (wgm == tcw_pkg::WGM_PHASE);
    wire at_max   = (count_q == tcw_pkg::COUNT_MAX);

    // comparator sees the live compare value directly outside PWM
    wire [7:0] cmp_eff = is_pwm ? cmp_act_q : cmp_buf_q; // see RL14 see RL22
    // a count write blocks the match of the following tick
    wire match    = (count_q == cmp_eff) && !block_q; // see RL25
    wire match_ev = tick && match && !is_phase;        // see RL26

    wire force_ev = wr_ctrl && wdata[tcw_pkg::CTRL_FORCE_BIT]
                    && !is_pwm;                        // see RL7

    // ************************************************
    // counter next value
    // ************************************************
    always_comb begin
        count_d = count_q;
        if (tick) begin // see RL26
            case (wgm)
                tcw_pkg::WGM_NORMAL: count_d = count_q + 8'h01; // see RL9
                // a late compare is missed, so the count wraps past 0xFF
                tcw_pkg::WGM_CLEAR: begin // see RL12 see RL13
                    count_d = match ? tcw_pkg::COUNT_BOTTOM
                                    : count_q + 8'h01;
                end
                tcw_pkg::WGM_FAST: count_d = count_q + 8'h01; // see RL18
                default: count_d = count_q;
            endcase
        end
        if (wr_count) begin
            count_d = wdata; // see RL11
        end
    end

    // overflow on the roll from max; still set when a count write lands on that tick
    wire ovf_ev = tick && at_max && !is_phase; // see RL10 see RL17 see RL20

    // ************************************************
    // waveform output next value
    // ************************************************
    function automatic logic act(input logic [1:0] com, input logic cur);
        case (com)
            tcw_pkg::COM_TOGGLE: act = ~cur;
            tcw_pkg::COM_CLEAR:  act = 1'b0;
            tcw_pkg::COM_SET:    act = 1'b1;
            default:             act = cur;
        endcase
    endfunction : act

    always_comb begin
        wave_d = wave_q;
        if (is_fast && tick) begin
            // bottom edge first so a match at max (or zero) wins
            if (at_max && com_q[1]) begin
                wave_d = ~com_q[0]; // see RL19 see RL21
            end
            if (match && com_q[1]) begin
                wave_d = com_q[0]; // see RL19 see RL21
            end
            if (match && com_q == tcw_pkg::COM_TOGGLE) begin
                wave_d = ~wave_q;
            end
        end else if (!is_pwm && match_ev) begin
            wave_d = act(com_q, wave_q); // see RL5 see RL6 see RL15
        end
        if (force_ev) begin
            wave_d = act(wdata[tcw_pkg::CTRL_COM_LSB +: 2], wave_q); // see RL7
        end
    end

    // ************************************************
    // state registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            com_q   <= tcw_pkg::COM_OFF;
            wgm_q   <= 2'h0;
            count_q <= tcw_pkg::RESET_BYTE;
            wave_q  <= 1'b0; // see RL4
        end else begin
            if (wr_ctrl) begin
                // mode counts from the next match, no double buffer
                com_q <= wdata[tcw_pkg::CTRL_COM_LSB +: 2]; // see RL6
                wgm_q <= wdata[tcw_pkg::CTRL_WGM_LSB +: 2]; // see RL8
            end
            count_q <= count_d; // see RL24
            wave_q  <= wave_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_buf_q <= tcw_pkg::RESET_BYTE;
            cmp_act_q <= tcw_pkg::RESET_BYTE;
            block_q   <= 1'b0;
        end else begin
            if (wr_cmp) begin
                cmp_buf_q <= wdata;
            end
            // pwm copy reloads at top; outside pwm it tracks the buffer
            if (!is_pwm || (tick && at_max)) begin // see RL22
                cmp_act_q <= wr_cmp ? wdata : cmp_buf_q;
            end
            // blocking lasts until the next tick, even if ticks are stopped
            if (wr_count) begin
                block_q <= 1'b1; // see RL25
            end else if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
            cmp_q <= 1'b0;
        end else begin
            if (ovf_ev) begin
                ovf_q <= 1'b1; // see RL10
            end else if ((wr_flags && wdata[tcw_pkg::FLAG_OVF_BIT])
                         || irq_ack_ovf) begin
                ovf_q <= 1'b0;
            end
            if (match_ev) begin
                cmp_q <= 1'b1; // see RL16 see RL23
            end else if ((wr_flags && wdata[tcw_pkg::FLAG_CMP_BIT])
                         || irq_ack_cmp) begin
                cmp_q <= 1'b0; // see RL23
            end
        end
    end

    // ************************************************
    // port pin and read back
    // ************************************************
    wire pin_sel = (com_q != tcw_pkg::COM_OFF) ? wave_q
                                                : port_out_q; // see RL1 see RL3

    always_comb begin
        rdata_q_d = 8'h00;
        case (bus.addr)
            tcw_pkg::ADDR_CTRL:  rdata_q_d = {2'b00, com_q, 2'b00, wgm_q};
            tcw_pkg::ADDR_COUNT: rdata_q_d = count_q;
            tcw_pkg::ADDR_CMP:   rdata_q_d = cmp_buf_q;
            tcw_pkg::ADDR_FLAGS: rdata_q_d = {6'h00, cmp_q, ovf_q};
            tcw_pkg::ADDR_PORT:  rdata_q_d = {5'h00, wave_q, port_dir_q,
                                              port_out_q};
            default:             rdata_q_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_out_q <= 1'b0;
            port_dir_q <= 1'b0;
            pin_out_q  <= 1'b0;
            pin_oe_q   <= 1'b0;
            rdata_q    <= 8'h00;
        end else begin
            if (wr_port) begin
                port_out_q <= wdata[tcw_pkg::PORT_OUT_BIT];
                port_dir_q <= wdata[tcw_pkg::PORT_DIR_BIT]; // see RL2
            end
            pin_out_q <= pin_sel;
            pin_oe_q  <= port_dir_q; // see RL2
            rdata_q   <= bus.rd ? rdata_q_d : 8'h00;
        end
    end

    assign rdata    = rdata_q;
    assign pin_out  = pin_out_q;
    assign pin_oe   = pin_oe_q;
    assign ovf_flag = ovf_q;
    assign cmp_flag = cmp_q;

    // ************************************************
    // checks
    // ************************************************
    reset_wave_a: assert property (@(posedge clk) // see RL4
        rst |=> !wave_q) else $error("wave not cleared by reset");

    pin_override_a: assert property (@(posedge clk) disable iff (rst) // see RL1
        (com_q != 2'h0) |=> pin_out_q == $past(wave_q))
        else $error("pin not following waveform output");

    com_off_hold_a: assert property (@(posedge clk) disable iff (rst) // see RL5
        (com_q == 2'h0 && !force_ev && !is_fast) |=> $stable(wave_q))
        else $error("wave changed with output mode off");

    normal_wrap_a: assert property (@(posedge clk) disable iff (rst) // see RL9
        (wgm_q == 2'h0 && tick && !wr_count && at_max) |=> count_q == 8'h00)
        else $error("normal mode did not wrap");

    ovf_set_a: assert property (@(posedge clk) disable iff (rst) // see RL10
        (tick && at_max && !is_phase) |=> ovf_q)
        else $error("overflow flag not set at max");

    match_clear_a: assert property ( // see RL12
        @(posedge clk) disable iff (rst)
        (is_clear && tick && match && !wr_count)
        |=> count_q == 8'h00 && cmp_q)
        else $error("count not cleared on match");

    match_toggle_a: assert property ( // see RL15
        @(posedge clk) disable iff (rst)
        (is_clear && com_q == 2'h1 && match_ev && !force_ev)
        |=> wave_q != $past(wave_q)) else $error("toggle on match missing");

    fast_clear_a: assert property (@(posedge clk) disable iff (rst) // see RL19
        (is_fast && com_q == 2'h2 && tick && match && !force_ev) |=> !wave_q)
        else $error("fast pwm not cleared at match");

    block_match_a: assert property (@(posedge clk) disable iff (rst) // see RL25
        wr_count |=> !match ##0 !cmp_q || $past(cmp_q))
        else $error("compare match not blocked after count write");

    force_noflag_a: assert property (@(posedge clk) disable iff (rst) // see RL24
        (force_ev && !match_ev && !cmp_q) |=> !cmp_q)
        else $error("force strobe set compare flag");

    // ************************************************
    // checks: counter and compare copy
    // ************************************************
    fast_wrap_a: assert property ( // see RL18
        @(posedge clk) disable iff (rst)
        (is_fast && tick && at_max && !wr_count) |=> count_q == 8'h00)
        else $error("fast pwm did not restart from bottom");

    tick_gate_a: assert property ( // see RL26
        @(posedge clk) disable iff (rst)
        (!tick && !wr_count) |=> $stable(count_q))
        else $error("count moved without a timer tick");

    cmp_direct_a: assert property ( // see RL14
        @(posedge clk) disable iff (rst)
        (!is_pwm && wr_cmp) |=> cmp_eff == $past(wdata))
        else $error("compare write not live outside pwm");

    cmp_hold_a: assert property ( // see RL22
        @(posedge clk) disable iff (rst)
        (is_pwm && !(tick && at_max)) |=> $stable(cmp_act_q))
        else $error("pwm compare copy moved before top");

    cmp_reload_a: assert property ( // see RL22
        @(posedge clk) disable iff (rst)
        (is_pwm && tick && at_max && !wr_cmp) |=> cmp_act_q == cmp_buf_q)
        else $error("pwm compare copy not reloaded at top");

    // ************************************************
    // checks: waveform output, pin and flags
    // ************************************************
    fast_set_a: assert property ( // see RL19
        @(posedge clk) disable iff (rst)
        (is_fast && com_q == 2'h2 && tick && at_max && !match) |=> wave_q)
        else $error("fast pwm not set at bottom");

    fast_match_a: assert property ( // see RL21
        @(posedge clk) disable iff (rst)
        (is_fast && com_q[1] && tick && match) |=> wave_q == $past(com_q[0]))
        else $error("fast pwm level wrong at match");

    wave_gate_a: assert property ( // see RL26
        @(posedge clk) disable iff (rst)
        (!tick && !force_ev) |=> $stable(wave_q))
        else $error("waveform output moved without a tick");

    force_toggle_a: assert property ( // see RL7
        @(posedge clk) disable iff (rst)
        (force_ev && !tick && wdata[tcw_pkg::CTRL_COM_LSB +: 2] == 2'h1)
        |=> wave_q != $past(wave_q)) else $error("forced toggle not applied");

    port_pass_a: assert property ( // see RL3
        @(posedge clk) disable iff (rst)
        (com_q == 2'h0) |=> pin_out_q == $past(port_out_q))
        else $error("pin not following port value");

    cmp_set_a: assert property ( // see RL23
        @(posedge clk) disable iff (rst)
        match_ev |=> cmp_q)
        else $error("match did not set compare flag");

    cmp_clear_a: assert property ( // see RL23
        @(posedge clk) disable iff (rst)
        (wr_flags && wdata[tcw_pkg::FLAG_CMP_BIT] && !match_ev) |=> !cmp_q)
        else $error("compare flag not cleared by write");

    ovf_hold_a: assert property ( // see RL10
        @(posedge clk) disable iff (rst)
        (ovf_q && !wr_flags && !irq_ack_ovf) |=> ovf_q)
        else $error("overflow flag cleared by hardware");

    flag_gate_a: assert property ( // see RL26
        @(posedge clk) disable iff (rst)
        !tick |=> !$rose(ovf_q) && !$rose(cmp_q))
        else $error("flag set without a timer tick");

endmodule : tcw_timer

`default_nettype wire

/* verif/tcw_pin_load.sv */
// Purpose: load on the port pin that the compare output can take over
// Assumes: weak pull-down on the board side of the pin
// Notes:   level follows the block only while it drives the pin
`timescale 1ns/100ps
`default_nettype none

module tcw_pin_load (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // released pin settles to the pull-down, never to the last value
    assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule : tcw_pin_load

`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for the timer compare unit
// Assumes: the bench makes tick, one pulse per timer clock
// Notes:   tick stays low around register access so reads are stable
`timescale 1ns/100ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [1:0] wgm;
        logic [1:0] com;
        logic       w0;
        logic [7:0] start;
        logic [7:0] cmpv;
        logic [7:0] n;
        logic [7:0] e_cnt;
        logic [1:0] e_flg;
        logic       e_wave;
    } tcw_row_s;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              tick = 1'b0;
    logic              ack_ovf = 1'b0;
    logic              ack_cmp = 1'b0;
    tcw_pkg::tcw_bus_s bus = '0;
    logic [7:0]        rdata;
    logic              pin_out;
    logic              pin_oe;
    logic              ovf_flag;
    logic              cmp_flag;
    logic              pin_level;
    logic [7:0]        d;
    int                mismatches = 0;
    int                compares = 0;
    tcw_row_s          rows [0:10];

    always #12.5 clk = ~clk;

    tcw_timer u_dut (
        .clk(clk), .rst(rst), .tick(tick), .addr(bus.addr),
        .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
        .irq_ack_ovf(ack_ovf), .irq_ack_cmp(ack_cmp), .rdata(rdata),
        .pin_out(pin_out), .pin_oe(pin_oe), .ovf_flag(ovf_flag),
        .cmp_flag(cmp_flag)
    );

    tcw_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe),
                         .pin_level(pin_level));

    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
        end
        @(posedge clk);
        tick <= 1'b0;
    endtask : ticks

    task automatic pulse_ack(input bit cmp);
        @(posedge clk);
        if (cmp) ack_cmp <= 1'b1; else ack_ovf <= 1'b1;
        @(posedge clk);
        ack_cmp <= 1'b0;
        ack_ovf <= 1'b0;
    endtask : pulse_ack

    // first tick after the count write never matches
    task automatic run_row(input tcw_row_s r);
        wr_reg(tcw_pkg::ADDR_CTRL, 8'h00);
        wr_reg(tcw_pkg::ADDR_CTRL, {2'h2, r.w0 ? tcw_pkg::COM_SET
                                    : tcw_pkg::COM_CLEAR, 4'h0});
        wr_reg(tcw_pkg::ADDR_COUNT, r.start);
        wr_reg(tcw_pkg::ADDR_CMP, r.cmpv);
        wr_reg(tcw_pkg::ADDR_CTRL, {2'h0, r.com, 2'h0, r.wgm});
        wr_reg(tcw_pkg::ADDR_FLAGS, 8'h03);
        ticks(r.n);
        rd_reg(tcw_pkg::ADDR_COUNT, d);
        check(d, r.e_cnt, "count");
        rd_reg(tcw_pkg::ADDR_FLAGS, d);
        check(d, {6'h00, r.e_flg}, "flags");
        rd_reg(tcw_pkg::ADDR_PORT, d);
        check(d, {5'h00, r.e_wave, 2'h2}, "wave");
        check({7'h00, pin_level}, {7'h00, (r.com != 2'h0) & r.e_wave},
              "pin");
    endtask : run_row

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("wrong value at %0t: run hung", $time);
        report_and_stop();
    end

    initial begin
        // wgm com w0 start cmp n | count flags wave
        rows[0]  = '{2'h0, 2'h1, 1'h0, 8'h00, 8'h05, 8'h08, 8'h08, 2'h2, 1'h1};
        rows[1]  = '{2'h0, 2'h2, 1'h1, 8'hFC, 8'h10, 8'h06, 8'h02, 2'h1, 1'h1};
        rows[2]  = '{2'h0, 2'h0, 1'h1, 8'h00, 8'h05, 8'h08, 8'h08, 2'h2, 1'h1};
        rows[3]  = '{2'h0, 2'h1, 1'h0, 8'h05, 8'h05, 8'h01, 8'h06, 2'h0, 1'h0};
        rows[4]  = '{2'h2, 2'h1, 1'h0, 8'h00, 8'h03, 8'h05, 8'h01, 2'h2, 1'h1};
        rows[5]  = '{2'h2, 2'h3, 1'h0, 8'hF0, 8'h02, 8'h13, 8'h00, 2'h3, 1'h1};
        rows[6]  = '{2'h3, 2'h2, 1'h1, 8'h7E, 8'h80, 8'h03, 8'h81, 2'h2, 1'h0};
        rows[7]  = '{2'h3, 2'h3, 1'h1, 8'hFE, 8'h80, 8'h02, 8'h00, 2'h1, 1'h0};
        rows[8]  = '{2'h3, 2'h2, 1'h0, 8'hFE, 8'h80, 8'h02, 8'h00, 2'h1, 1'h1};
        rows[9]  = '{2'h1, 2'h2, 1'h1, 8'h10, 8'h20, 8'h04, 8'h10, 2'h0, 1'h1};
        rows[10] = '{2'h0, 2'h1, 1'h0, 8'h40, 8'h41, 8'h00, 8'h40, 2'h0, 1'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wr_reg(tcw_pkg::ADDR_PORT, 8'h02);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // forced action: no flag, no count change; ignored in fast mode
        wr_reg(tcw_pkg::ADDR_CTRL, 8'h90);
        rd_reg(tcw_pkg::ADDR_PORT, d);
        check(d, 8'h06, "force wave");
        rd_reg(tcw_pkg::ADDR_COUNT, d);
        check(d, 8'h40, "force count");
        rd_reg(tcw_pkg::ADDR_FLAGS, d);
        check(d, 8'h00, "force flags");
        wr_reg(tcw_pkg::ADDR_CTRL, 8'h23);
        wr_reg(tcw_pkg::ADDR_CTRL, 8'hA3);
        rd_reg(tcw_pkg::ADDR_PORT, d);
        check(d, 8'h06, "force in pwm");
        rd_reg(tcw_pkg::ADDR_CTRL, d);
        check(d, 8'h23, "ctrl readback");
        $display("force test done");
        // both flags set, then cleared one by one by the service acks
        wr_reg(tcw_pkg::ADDR_CTRL, 8'h10);
        wr_reg(tcw_pkg::ADDR_COUNT, 8'hFF);
        wr_reg(tcw_pkg::ADDR_CMP, 8'h00);
        ticks(2);
        #1 check({6'h00, cmp_flag, ovf_flag}, 8'h03, "flag pins");
        pulse_ack(1'b0);
        rd_reg(tcw_pkg::ADDR_FLAGS, d);
        check(d, 8'h02, "ovf ack");
        pulse_ack(1'b1);
        rd_reg(tcw_pkg::ADDR_FLAGS, d);
        check(d, 8'h00, "cmp ack");
        $display("ack test done");
        // port value and direction while the override is off
        wr_reg(tcw_pkg::ADDR_CTRL, 8'h00);
        wr_reg(tcw_pkg::ADDR_PORT, 8'h01);
        repeat (3) @(posedge clk);
        #1 check({6'h00, pin_oe, pin_level}, 8'h00, "released");
        wr_reg(tcw_pkg::ADDR_PORT, 8'h03);
        repeat (3) @(posedge clk);
        #1 check({6'h00, pin_oe, pin_out}, 8'h03, "port drive");
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, d);
        check(d, 8'h00, "unmapped");
        $display("pin test done");
        // second reset in mid-run with the output register high
        wr_reg(tcw_pkg::ADDR_CTRL, 8'hB0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(tcw_pkg::ADDR_PORT, d);
        check(d, 8'h00, "reset wave");
        rd_reg(tcw_pkg::ADDR_COUNT, d);
        check(d, 8'h00, "reset count");
        check({6'h00, pin_oe, pin_out}, 8'h00, "reset pin");
        $display("reset test done");
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
